/* File: logic/temp_sensor_config_alert.sv */
module temp_sensor_config_alert #(
  parameter logic [temp_cfg_pkg::CNT_W-1:0] CYC_Q =
    temp_cfg_pkg::CNT_W'(temp_cfg_pkg::PERIOD_MS_Q * temp_cfg_pkg::CYC_PER_MS),
  parameter logic [temp_cfg_pkg::CNT_W-1:0] CYC_1 =
    temp_cfg_pkg::CNT_W'(temp_cfg_pkg::PERIOD_MS_1 * temp_cfg_pkg::CYC_PER_MS),
  parameter logic [temp_cfg_pkg::CNT_W-1:0] CYC_4 =
    temp_cfg_pkg::CNT_W'(temp_cfg_pkg::PERIOD_MS_4 * temp_cfg_pkg::CYC_PER_MS),
  parameter logic [temp_cfg_pkg::CNT_W-1:0] CYC_8 =
    temp_cfg_pkg::CNT_W'(temp_cfg_pkg::PERIOD_MS_8 * temp_cfg_pkg::CYC_PER_MS)
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // operating_control access from the serial front end
  input  wire logic        ctrl_wr,
  input  wire logic [15:0] ctrl_wdata,
  output logic [15:0]      ctrl_rdata,
  // conversion engine
  output logic             conv_start,
  input  wire logic        temp_valid,
  input  wire logic [15:0] temp_value,
  // limits, left-justified in the same format as results
  input  wire logic [15:0] limit_high,
  input  wire logic [15:0] limit_low,
  // decoded state for neighbouring logic
  output logic             over_temp,
  output logic             ext_range,
  output logic             intr_mode,
  output logic             powered_down
);

  typedef struct packed {
    logic [1:0]  rate;
    logic        ext;
    logic [1:0]  fault;
    logic        alert_polarity;
    logic        mode;
    logic        down;
    logic        active;
    logic [2:0]  streak;
    logic        busy;
    logic [15:0] rdata;
  } ctl_state_t;

  ctl_state_t st_reg;
  ctl_state_t st_next;
  logic       tick;

  // consecutive readings required per fault code
  function automatic logic [2:0] need_of(input logic [1:0] f);
    case (f)
      2'h0:    need_of = temp_cfg_pkg::NEED_F0;
      2'h1:    need_of = temp_cfg_pkg::NEED_F1;
      2'h2:    need_of = temp_cfg_pkg::NEED_F2;
      default: need_of = temp_cfg_pkg::NEED_F3;
    endcase
  endfunction

  // signed value of a left-justified word in the chosen width
  function automatic logic signed [12:0] value_of(input logic [15:0] w, input logic ext);
    if (ext) begin
      value_of = w[15:3];
    end else begin
      value_of = {w[15], w[15:4]};
    end
  endfunction

  // alarm bit as software sees it
  function automatic logic alarm_bit(input logic active, input logic alert_polarity);
    alarm_bit = active ~^ alert_polarity;
  endfunction

  rate_divider #(
    .CYC_Q (CYC_Q),
    .CYC_1 (CYC_1),
    .CYC_4 (CYC_4),
    .CYC_8 (CYC_8)
  ) u_div (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (!st_reg.down),
    .rate    (st_reg.rate),
    .tick    (tick)
  );

  logic signed [12:0] t_val;
  logic signed [12:0] hi_val;
  logic signed [12:0] lo_val;
  logic               hit;

  // compare in the active format; limits follow the same width
  always_comb begin
    t_val  = value_of(temp_value, st_reg.ext);
    hi_val = value_of(limit_high, st_reg.ext);
    lo_val = value_of(limit_low, st_reg.ext);
    hit    = st_reg.active ? (t_val < lo_val) : (t_val >= hi_val);
  end

  // readback word of a given state; a function keeps the next-state logic free of a comb loop
  function automatic logic [15:0] readback_of(input ctl_state_t s);
    readback_of                              = 16'h0000;
    readback_of[temp_cfg_pkg::RATE_HI_BIT]   = s.rate[1];
    readback_of[temp_cfg_pkg::RATE_LO_BIT]   = s.rate[0];
    readback_of[temp_cfg_pkg::ALARM_BIT]     = alarm_bit(s.active, s.alert_polarity);
    readback_of[temp_cfg_pkg::EXT_BIT]       = s.ext;
    readback_of[temp_cfg_pkg::IDLE_BIT]      = !s.busy;
    readback_of[temp_cfg_pkg::RES_HI_BIT]    = temp_cfg_pkg::RES_VAL[1];
    readback_of[temp_cfg_pkg::RES_LO_BIT]    = temp_cfg_pkg::RES_VAL[0];
    readback_of[temp_cfg_pkg::FAULT_HI_BIT]  = s.fault[1];
    readback_of[temp_cfg_pkg::FAULT_LO_BIT]  = s.fault[0];
    readback_of[temp_cfg_pkg::POL_BIT]       = s.alert_polarity;
    readback_of[temp_cfg_pkg::MODE_BIT]      = s.mode;
    readback_of[temp_cfg_pkg::DOWN_BIT]      = s.down;
  endfunction

  // next state
  always_comb begin
    st_next = st_reg;

    // writable fields only; alarm, idle and resolution bits ignore writes
    if (ctrl_wr) begin
      st_next.rate  = {ctrl_wdata[temp_cfg_pkg::RATE_HI_BIT],
                       ctrl_wdata[temp_cfg_pkg::RATE_LO_BIT]};
      st_next.ext   = ctrl_wdata[temp_cfg_pkg::EXT_BIT];
      st_next.fault = {ctrl_wdata[temp_cfg_pkg::FAULT_HI_BIT],
                       ctrl_wdata[temp_cfg_pkg::FAULT_LO_BIT]};
      st_next.alert_polarity   = ctrl_wdata[temp_cfg_pkg::POL_BIT];
      st_next.mode  = ctrl_wdata[temp_cfg_pkg::MODE_BIT];
      st_next.down  = ctrl_wdata[temp_cfg_pkg::DOWN_BIT];
    end

    // a conversion in flight finishes even if power-down arrives meanwhile
    if (tick) begin
      st_next.busy = 1'b1;
    end else if (temp_valid) begin
      st_next.busy = 1'b0;
    end

    // fault streak; mode bit deliberately not consulted here
    if (temp_valid) begin
      if (hit) begin
        if (st_reg.streak + 3'h1 >= need_of(st_reg.fault)) begin
          st_next.active = !st_reg.active;
          st_next.streak = 3'h0;
        end else begin
          st_next.streak = st_reg.streak + 3'h1;
        end
      end else begin
        st_next.streak = 3'h0; // consecutive only
      end
    end

    st_next.rdata = readback_of(st_next);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '{rate:   temp_cfg_pkg::RATE_RST,
                  ext:    temp_cfg_pkg::EXT_RST,
                  fault:  temp_cfg_pkg::FAULT_RST,
                  alert_polarity:    temp_cfg_pkg::POL_RST,
                  mode:   temp_cfg_pkg::MODE_RST,
                  down:   temp_cfg_pkg::DOWN_RST,
                  active: 1'b0,
                  streak: 3'h0,
                  busy:   1'b1, // idle bit reads 0 until the first result, matching the reset word
                  rdata:  temp_cfg_pkg::CTRL_RST};
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign ctrl_rdata   = st_reg.rdata;
  assign conv_start   = tick;
  assign over_temp    = st_reg.active;
  assign ext_range    = st_reg.ext;
  assign intr_mode    = st_reg.mode;
  assign powered_down = st_reg.down;

endmodule // temp_sensor_config_alert

/* File: inc/temp_cfg_pkg.sv */
package temp_cfg_pkg;

  // clock and conversion periods
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned PERIOD_MS_Q   = 4000;   // 0.25 Hz
  localparam int unsigned PERIOD_MS_1   = 1000;   // 1 Hz
  localparam int unsigned PERIOD_MS_4   = 250;    // 4 Hz
  localparam int unsigned PERIOD_MS_8   = 125;    // 8 Hz
  localparam int unsigned CNT_W         = 27;

  // rate codes
  localparam logic [1:0] RATE_Q         = 2'h0;
  localparam logic [1:0] RATE_1         = 2'h1;
  localparam logic [1:0] RATE_4         = 2'h2;
  localparam logic [1:0] RATE_8         = 2'h3;

  // operating_control field positions
  localparam int unsigned RATE_HI_BIT   = 15;
  localparam int unsigned RATE_LO_BIT   = 14;
  localparam int unsigned ALARM_BIT     = 13;
  localparam int unsigned EXT_BIT       = 12;
  localparam int unsigned IDLE_BIT      = 7;
  localparam int unsigned RES_HI_BIT    = 6;
  localparam int unsigned RES_LO_BIT    = 5;
  localparam int unsigned FAULT_HI_BIT  = 4;
  localparam int unsigned FAULT_LO_BIT  = 3;
  localparam int unsigned POL_BIT       = 2;
  localparam int unsigned MODE_BIT      = 1;
  localparam int unsigned DOWN_BIT      = 0;

  // reset values
  localparam logic [1:0]  RATE_RST      = RATE_4;
  localparam logic [1:0]  FAULT_RST     = 2'h0;
  localparam logic        POL_RST       = 1'b0;
  localparam logic        MODE_RST      = 1'b0;
  localparam logic        EXT_RST       = 1'b0;
  localparam logic        DOWN_RST      = 1'b0;
  localparam logic [1:0]  RES_VAL       = 2'h3;
  localparam logic [15:0] CTRL_RST      = 16'ha060;

  // fault count codes and required counts
  localparam logic [2:0]  NEED_F0       = 3'h1;
  localparam logic [2:0]  NEED_F1       = 3'h2;
  localparam logic [2:0]  NEED_F2       = 3'h4;
  localparam logic [2:0]  NEED_F3       = 3'h6;

endpackage

/* File: logic/rate_divider.sv */
module rate_divider #(
  parameter logic [temp_cfg_pkg::CNT_W-1:0] CYC_Q = 27'h0,
  parameter logic [temp_cfg_pkg::CNT_W-1:0] CYC_1 = 27'h0,
  parameter logic [temp_cfg_pkg::CNT_W-1:0] CYC_4 = 27'h0,
  parameter logic [temp_cfg_pkg::CNT_W-1:0] CYC_8 = 27'h0
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // control
  input  wire logic       run,
  input  wire logic [1:0] rate,
  // tick out
  output logic            tick
);

  typedef struct packed {
    logic [temp_cfg_pkg::CNT_W-1:0] cnt;
    logic [1:0]                     rate;
    logic                           tick;
  } div_state_t;

  div_state_t st_reg;
  div_state_t st_next;

  function automatic logic [temp_cfg_pkg::CNT_W-1:0] period_of(input logic [1:0] r);
    case (r)
      temp_cfg_pkg::RATE_Q: period_of = CYC_Q;
      temp_cfg_pkg::RATE_1: period_of = CYC_1;
      temp_cfg_pkg::RATE_4: period_of = CYC_4;
      default:              period_of = CYC_8;
    endcase
  endfunction

  // count down; a rate change restarts the period so no short first interval
  always_comb begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    st_next.rate = rate;
    if (!run || rate != st_reg.rate) begin
      st_next.cnt = period_of(rate) - 27'h1;
    end else if (st_reg.cnt == '0) begin
      st_next.tick = 1'b1;
      st_next.cnt  = period_of(rate) - 27'h1;
    end else begin
      st_next.cnt = st_reg.cnt - 27'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '{cnt: '0, rate: temp_cfg_pkg::RATE_RST, tick: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

endmodule // rate_divider

/* File: sim/conv_engine_model.sv */
// behavioural conversion engine on the far side of conv_start
module conv_engine_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // conversion link
  input  wire logic        conv_start,
  output logic             temp_valid,
  output logic [15:0]      temp_value,
  // bench controls: slow answer, next result
  input  wire logic        slow,
  input  wire logic [15:0] temp_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // a new start restarts the count, so slow stays under the shortest period
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt        <= 0;
      temp_valid <= 1'b0;
      temp_value <= 16'h0000;
    end else begin
      temp_valid <= 1'b0;
      if (conv_start) cnt <= slow ? 4 : 1;
      else if (cnt == 1) begin
        temp_valid <= 1'b1;
        temp_value <= temp_in;
        cnt        <= 0;
      end else if (cnt > 1) cnt <= cnt - 1;
      else temp_value <= ~temp_value; // result is stale outside the strobe
    end
  end
endmodule // conv_engine_model

/* File: sim/temp_sensor_config_alert_assertions.sv */
module alert_checker (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        ctrl_wr,
  input wire logic [15:0] ctrl_wdata,
  input wire logic [15:0] ctrl_rdata,
  input wire logic        conv_start,
  input wire logic        temp_valid,
  input wire logic [15:0] temp_value,
  input wire logic [15:0] limit_high,
  input wire logic [15:0] limit_low,
  input wire logic        over_temp,
  input wire logic        ext_range,
  input wire logic        intr_mode,
  input wire logic        powered_down
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // signed reading of a left-justified word in the chosen width
  function automatic logic signed [12:0] fmt(input logic [15:0] w, input logic e);
    fmt = e ? w[15:3] : {w[15], w[15:4]};
  endfunction
  // written fields land one cycle after the strobe
  a_rate_write: assert property (ctrl_wr |=> ctrl_rdata[15:14] == $past(ctrl_wdata[15:14]))
    else $error("rate field not taken");
  a_ext_write: assert property (ctrl_wr |=> ext_range == $past(ctrl_wdata[12]))
    else $error("extended bit not taken");
  a_mode_write: assert property (ctrl_wr |=> intr_mode == $past(ctrl_wdata[1]))
    else $error("mode bit not taken");
  a_down_write: assert property (ctrl_wr |=> powered_down == $past(ctrl_wdata[0]))
    else $error("power-down bit not taken");
  a_down_quiet: assert property (powered_down && $past(powered_down) |-> !conv_start)
    else $error("start while powered down");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  a_alarm_polarity: assert property (ctrl_rdata[13] == (over_temp ~^ ctrl_rdata[2]))
    else $error("alarm bit disagrees with state");
  a_alarm_cause: assert property ($changed(over_temp) |-> $past(temp_valid))
    else $error("alarm moved without a result");
  a_rise_cause: assert property ($rose(over_temp) |->
    fmt($past(temp_value), $past(ext_range)) >= fmt($past(limit_high), $past(ext_range)))
    else $error("alarm rose below high limit");
  a_fall_cause: assert property ($fell(over_temp) |->
    fmt($past(temp_value), $past(ext_range)) < fmt($past(limit_low), $past(ext_range)))
    else $error("alarm fell at or above low limit");
  a_single_fault: assert property (!ctrl_wr && ctrl_rdata[4:3] == 2'h0 && temp_valid && !over_temp
    && fmt(temp_value, ext_range) >= fmt(limit_high, ext_range) |=> over_temp)
    else $error("single fault did not trip");
  c_rise: cover property ($rose(over_temp));
  c_fall: cover property ($fell(over_temp));
  c_down: cover property (ctrl_wr && ctrl_wdata[0]);
endmodule // alert_checker
bind temp_sensor_config_alert alert_checker u_chk (.clk(clk), .reset_n(reset_n), .ctrl_wr(ctrl_wr),
  .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata), .conv_start(conv_start), .temp_valid(temp_valid),
  .temp_value(temp_value), .limit_high(limit_high), .limit_low(limit_low), .over_temp(over_temp),
  .ext_range(ext_range), .intr_mode(intr_mode), .powered_down(powered_down));

/* File: sim/temp_sensor_config_alert_bench.sv */
module temp_sensor_config_alert_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset_n = 1'b0, ctrl_wr = 1'b0, slow = 1'b0;
  logic [15:0] ctrl_wdata = 16'h0000, temp_in = 16'h0000, limit_high = 16'h5008, limit_low = 16'h4b00;
  logic [15:0] ctrl_rdata, temp_value, w;
  logic conv_start, temp_valid, over_temp, ext_range, intr_mode, powered_down;
  int fail_count = 0, checks = 0, cyc = 0, streak = 0, need, n;
  bit act = 0, pend = 0, hit, pol_m = 0, ext_m = 0;
  logic [1:0] flt_m = 2'h0;
  int per[4] = '{40, 20, 10, 5};
  logic [15:0] temps[6] = '{16'h5000, 16'h4ff0, 16'h4b00, 16'h4af0, 16'hc000, 16'h5008};
  // 12-bit reading drops bit 3, 13-bit reading keeps it
  function automatic int fmt(logic [15:0] v, bit e);
    return e ? int'($signed(v[15:3])) : int'($signed(v[15:4]));
  endfunction
  always #20 clk = ~clk;
  temp_sensor_config_alert #(.CYC_Q(27'd40), .CYC_1(27'd20), .CYC_4(27'd10), .CYC_8(27'd5)) DUT (
    .clk(clk), .reset_n(reset_n), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
    .conv_start(conv_start), .temp_valid(temp_valid), .temp_value(temp_value), .limit_high(limit_high),
    .limit_low(limit_low), .over_temp(over_temp), .ext_range(ext_range), .intr_mode(intr_mode),
    .powered_down(powered_down));
  conv_engine_model u_eng (.clk(clk), .reset_n(reset_n), .conv_start(conv_start), .temp_valid(temp_valid),
    .temp_value(temp_value), .slow(slow), .temp_in(temp_in));
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic final_report();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // mirror is refreshed after the write edge so checks never see a half-updated view
  task automatic wr(logic [15:0] v);
    @(posedge clk);
    #2 ctrl_wr = 1'b1;
    ctrl_wdata = v;
    @(posedge clk);
    #2 ctrl_wr = 1'b0;
    pol_m = v[2];
    flt_m = v[4:3];
    ext_m = v[12];
  endtask
  // reference alarm: consecutive hits against the limit that applies to the current state
  always @(posedge clk) begin
    pend <= 1'b0;
    if (reset_n && temp_valid) begin
      hit = act ? (fmt(temp_value, ext_m) < fmt(limit_low, ext_m))
                : (fmt(temp_value, ext_m) >= fmt(limit_high, ext_m));
      streak = hit ? streak + 1 : 0;
      need = (flt_m == 2'h0) ? 1 : (flt_m == 2'h1) ? 2 : (flt_m == 2'h2) ? 4 : 6;
      if (streak >= need) begin
        act = ~act;
        streak = 0;
      end
      pend <= 1'b1;
    end
  end
  always @(negedge clk) begin
    if (pend) begin
      chk("over_temp", {15'h0, act}, {15'h0, over_temp});
      chk("alarm_bit", {15'h0, ~(act ^ pol_m)}, {15'h0, ctrl_rdata[13]});
    end
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    void'($urandom(32'h3ab3));
    repeat (2) @(posedge clk);
    #2 reset_n = 1'b1;
    chk("reset_ctrl", 16'ha060, ctrl_rdata);
    // random field writes, status bits masked
    repeat (8) begin
      w = 16'($urandom);
      wr(w);
      chk("ctrl", {w[15:14], 1'b0, w[12], 7'h03, w[4:0]}, ctrl_rdata & 16'hdf7f);
      chk("decoded", {13'h0, w[12], w[1], w[0]}, {13'h0, ext_range, intr_mode, powered_down});
    end
    // every rate code, period measured between pulses
    for (int r = 0; r < 4; r++) begin
      wr({r[1:0], 14'h0000});
      @(negedge clk); // skip a pulse launched at the write edge under the old rate
      do @(negedge clk); while (!conv_start);
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (!conv_start);
      chk("period", 16'(per[r]), 16'(n));
    end
    // alarm under each fault code, random polarity and mode, prompt and slow answers
    for (int f = 0; f < 4; f++) begin
      wr({2'h3, 1'b0, 1'($urandom), 7'h00, f[1:0], 1'($urandom), 1'($urandom), 1'b0});
      repeat (24) begin
        do begin
          @(posedge clk);
          #2;
        end while (!temp_valid);
        temp_in = temps[$urandom % 6];
        slow = 1'($urandom);
      end
    end
    // power-down stops conversions
    wr(16'h0001);
    @(negedge clk); // a pulse launched at the write edge itself is allowed
    n = 0;
    repeat (60) begin
      @(negedge clk);
      if (conv_start) n++;
    end
    chk("starts_down", 16'h0, 16'(n));
    chk("ctrl_down", 16'h00e1, ctrl_rdata & 16'hdfff);
    final_report();
  end
endmodule // temp_sensor_config_alert_bench
